// ### verilog/dil_defines.vh
// Constants shared by the depressurization initiation logic files.
`ifndef DIL_DEFINES_VH
`define DIL_DEFINES_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DIL_CLK_NS 50
`define DIL_TICK_US 1000
`define DIL_TICK_CYC ((`DIL_TICK_US * 1000) / `DIL_CLK_NS)
`define DIL_BYP_MIN 13
`define DIL_BYP_TICKS ((`DIL_BYP_MIN * 60 * 1000000) / `DIL_TICK_US)
`define DIL_ACT_S 130
`define DIL_ACT_TICKS ((`DIL_ACT_S * 1000000) / `DIL_TICK_US)

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define DIL_AW 8
`define DIL_CTRL_OFS 8'h00
`define DIL_STAT_OFS 8'h04
`define DIL_VALVE_OFS 8'h08
`define DIL_PB_HP 0
`define DIL_PB_BYP 1
`define DIL_PB_ACT 2
`define DIL_PB_LOGIC 3
`define DIL_ST_TRIP 0
`define DIL_ST_TIMING 4
`define DIL_ST_SEAL 8
`define DIL_ST_BYP 12
`define DIL_ST_INH 16
`define DIL_ST_AUTO 18
`define DIL_ST_TALM 19
`define DIL_ST_IALM 20
`define DIL_VS_SOL 0
`define DIL_VS_BUSB 8
`define DIL_VS_TRB 16
`define DIL_RESP_OKAY 2'h0
`define DIL_RESP_SLVERR 2'h2

`endif

// ### verilog/dil_trip_logic.v
// One trip logic: seal-in, bypass timer, actuation delay and trip latch.
`timescale 1ns/100ps
`include "dil_defines.vh"
module dil_trip_logic #(
  parameter [31:0] BYP_TICKS = `DIL_BYP_TICKS,
  parameter [31:0] ACT_TICKS = `DIL_ACT_TICKS
) (
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire lvl1,
  input wire lvl3,
  input wire hp,
  input wire perm,
  input wire inhibit,
  input wire hp_rst,
  input wire byp_rst,
  input wire act_rst,
  input wire logic_rst,
  output reg trip_r,
  output reg timing_r,
  output reg hp_seal_r,
  output reg bypass_r
);
  reg [31:0] byp_cnt_r;
  reg byp_run_r;
  reg byp_done_r;
  reg [31:0] act_cnt_r;
  reg act_done_r;

  // Resetting the initiation signals sends both timers back to zero.
  wire recycle = hp_rst | logic_rst;
  wire byp_clr = byp_rst | recycle;
  wire byp_count = byp_run_r & ~byp_done_r;
  wire byp_exp = byp_count & tick & (byp_cnt_r == BYP_TICKS - 32'h1);
  wire hp_ok = hp_seal_r | bypass_r;
  wire act_cond = lvl1 & lvl3 & hp_ok;
  wire act_count = act_cond & ~act_done_r;
  wire act_exp = act_count & tick & (act_cnt_r == ACT_TICKS - 32'h1);
  wire act_clr = act_rst | recycle | ~act_cond;
  wire init_ok = lvl1 & lvl3 & hp_ok & perm;

  always @(posedge aclk) begin
    if (!aresetn) begin
      hp_seal_r <= 1'b0;
      byp_run_r <= 1'b0;
      byp_cnt_r <= 32'h0;
      byp_done_r <= 1'b0;
      bypass_r <= 1'b0;
      act_cnt_r <= 32'h0;
      act_done_r <= 1'b0;
      trip_r <= 1'b0;
      timing_r <= 1'b0;
    end else begin
      // A live trip input wins over the reset button.
      hp_seal_r <= hp | (hp_seal_r & ~hp_rst);
      // The bypass timer keeps its state when level 1 drops; only a reset clears it.
      byp_run_r <= ~byp_clr & (byp_run_r | lvl1);
      if (byp_clr) begin
        byp_cnt_r <= 32'h0;
      end else if (byp_count & tick) begin
        byp_cnt_r <= byp_cnt_r + 32'h1;
      end
      byp_done_r <= ~byp_clr & (byp_done_r | byp_exp);
      bypass_r <= ~byp_clr & (bypass_r | (byp_exp & lvl1));
      if (act_clr) begin
        act_cnt_r <= 32'h0;
      end else if (act_count & tick) begin
        act_cnt_r <= act_cnt_r + 32'h1;
      end
      act_done_r <= ~act_clr & (act_done_r | act_exp);
      if (act_rst | (logic_rst & ~init_ok)) begin
        trip_r <= 1'b0;
      end else if (act_done_r & init_ok & ~inhibit) begin
        trip_r <= 1'b1;
      end
      timing_r <= byp_count | act_count;
    end
  end
endmodule

// ### verilog/dil_top.v
// Automatic depressurization initiation logic with AXI4-Lite status and control.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dil_defines.vh"
module dil_top #(
  parameter NV = 7,
  parameter [31:0] TICK_CYC = `DIL_TICK_CYC,
  parameter [31:0] BYP_TICKS = `DIL_BYP_TICKS,
  parameter [31:0] ACT_TICKS = `DIL_ACT_TICKS
) (
  input wire aclk,
  input wire aresetn,
  input wire [`DIL_AW-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`DIL_AW-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] level_low_low_in,
  input wire [3:0] level_low_in,
  input wire [3:0] cont_press_high_in,
  input wire [3:0] low_pressure_injection_press_in,
  input wire [1:0] spray_pump_press_in,
  input wire [1:0] inhibit_key_in,
  input wire seal_reset_pb_in,
  input wire bypass_reset_pb_in,
  input wire act_reset_pb_in,
  input wire logic_reset_pb_in,
  input wire [NV-1:0] manual_open_in,
  input wire [NV-1:0] backup_ovp_in,
  input wire bus_a_ok_in,
  input wire [NV-1:0] valve_bus_a_ok_in,
  output reg [NV-1:0] valve_sol_r,
  output reg [NV-1:0] sol_lamp_r,
  output reg timing_alarm_r,
  output reg inhibit_alarm_r,
  output reg [1:0] inhibit_lamp_r,
  output reg train_b_bus_b_r,
  output reg [NV-1:0] valve_bus_b_r
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every field input pin crosses two flops (the AXI pins do not); that lag is tiny against one timer tick.
  localparam NS = 25 + 3 * NV;
  wire [NS-1:0] raw = {level_low_low_in, level_low_in, cont_press_high_in,
    low_pressure_injection_press_in, spray_pump_press_in, inhibit_key_in,
    seal_reset_pb_in, bypass_reset_pb_in, act_reset_pb_in, logic_reset_pb_in,
    manual_open_in, backup_ovp_in, bus_a_ok_in, valve_bus_a_ok_in};
  wire [NS-1:0] syn;

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
      reg m_r;
      reg s_r;
      always @(posedge aclk) begin
        if (!aresetn) begin
          m_r <= 1'b0;
          s_r <= 1'b0;
        end else begin
          m_r <= raw[gi];
          s_r <= m_r;
        end
      end
      assign syn[gi] = s_r;
    end
  endgenerate

  wire [3:0] lvl1_s;
  wire [3:0] lvl3_s;
  wire [3:0] hp_s;
  wire [3:0] lpi_s;
  wire [1:0] spr_s;
  wire [1:0] inh_s;
  wire pb_hp_s;
  wire pb_byp_s;
  wire pb_act_s;
  wire pb_logic_s;
  wire [NV-1:0] man_s;
  wire [NV-1:0] ovp_s;
  wire bus_a_s;
  wire [NV-1:0] vbus_a_s;
  assign {lvl1_s, lvl3_s, hp_s, lpi_s, spr_s, inh_s, pb_hp_s, pb_byp_s, pb_act_s,
    pb_logic_s, man_s, ovp_s, bus_a_s, vbus_a_s} = syn;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  // One shared tick keeps the long timers narrow in their per-tick compare.
  // The prescaler runs free, so a timer's first tick lands up to TICK_CYC cycles late.
  reg [31:0] pre_r;
  reg tick_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (pre_r == TICK_CYC - 32'h1) begin
      pre_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      pre_r <= pre_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Trip logics
  // ----------------------------------------------------------------
  reg [3:0] sw_pb_r;
  wire hp_rst = pb_hp_s | sw_pb_r[`DIL_PB_HP];
  wire byp_rst = pb_byp_s | sw_pb_r[`DIL_PB_BYP];
  wire act_rst = pb_act_s | sw_pb_r[`DIL_PB_ACT];
  wire logic_rst = pb_logic_s | sw_pb_r[`DIL_PB_LOGIC];
  // The permissive and the inhibit keys are shared by all four logics.
  wire perm = |{lpi_s, spr_s};
  wire inhibit = &inh_s;
  wire [3:0] trip;
  wire [3:0] timing;
  wire [3:0] seal;
  wire [3:0] byp;

  // Logics 0 and 1 form train A, logics 2 and 3 form train B.
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_logic
      dil_trip_logic #(
        .BYP_TICKS(BYP_TICKS),
        .ACT_TICKS(ACT_TICKS)
      ) u_logic (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_r),
        .lvl1(lvl1_s[gi]),
        .lvl3(lvl3_s[gi]),
        .hp(hp_s[gi]),
        .perm(perm),
        .inhibit(inhibit),
        .hp_rst(hp_rst),
        .byp_rst(byp_rst),
        .act_rst(act_rst),
        .logic_rst(logic_rst),
        .trip_r(trip[gi]),
        .timing_r(timing[gi]),
        .hp_seal_r(seal[gi]),
        .bypass_r(byp[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Valve outputs, alarms and power selection
  // ----------------------------------------------------------------
  // Both logics of one train must trip; either train alone opens the valves.
  wire train_a_trip = trip[0] & trip[1];
  wire train_b_trip = trip[2] & trip[3];
  wire auto_open = train_a_trip | train_b_trip;
  wire [NV-1:0] sol_nxt;
  wire [NV-1:0] vbus_b_nxt;
  generate
    for (gi = 0; gi < NV; gi = gi + 1) begin : g_valve
      // Manual and backup demands reach the solenoid even while both trains are reset.
      assign sol_nxt[gi] = auto_open | man_s[gi] | ovp_s[gi];
      // Each valve follows its own power monitor, independent of the train supply.
      assign vbus_b_nxt[gi] = ~vbus_a_s[gi];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      valve_sol_r <= {NV{1'b0}};
      sol_lamp_r <= {NV{1'b0}};
      timing_alarm_r <= 1'b0;
      inhibit_alarm_r <= 1'b0;
      inhibit_lamp_r <= 2'h0;
      train_b_bus_b_r <= 1'b0;
      valve_bus_b_r <= {NV{1'b0}};
    end else begin
      valve_sol_r <= sol_nxt;
      sol_lamp_r <= sol_nxt;
      timing_alarm_r <= |timing;
      inhibit_alarm_r <= |inh_s;
      inhibit_lamp_r <= inh_s;
      // Supply returns to bus A once it is healthy again.
      // Healthy inputs read low for two clocks after reset, so bus B shows briefly.
      train_b_bus_b_r <= ~bus_a_s;
      valve_bus_b_r <= vbus_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  reg aw_full_r;
  reg w_full_r;
  reg [`DIL_AW-1:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  // A write commits once both halves are in and the last response has been taken.
  wire commit = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire [`DIL_AW-1:0] wofs = {aw_addr_r[`DIL_AW-1:2], 2'h0};
  wire w_ctrl = (wofs == `DIL_CTRL_OFS);
  wire w_stat = (wofs == `DIL_STAT_OFS);
  wire w_valve = (wofs == `DIL_VALVE_OFS);
  // Status and valve words are read-only, so writes there are accepted and dropped.
  wire w_hit = w_ctrl | w_stat | w_valve;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= {`DIL_AW{1'b0}};
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DIL_RESP_OKAY;
      sw_pb_r <= 4'h0;
    end else begin
      sw_pb_r <= 4'h0;
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (commit) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? `DIL_RESP_OKAY : `DIL_RESP_SLVERR;
        // Control bits act as momentary pushbuttons for one clock.
        // The pins, by contrast, act for as long as they are held.
        if (w_ctrl & w_strb_r[0]) begin
          sw_pb_r <= w_data_r[3:0];
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire [`DIL_AW-1:0] rofs = {s_axi_araddr[`DIL_AW-1:2], 2'h0};
  reg [31:0] stat_word;
  reg [31:0] valve_word;
  always @* begin
    stat_word = 32'h0;
    stat_word[`DIL_ST_TRIP +: 4] = trip;
    stat_word[`DIL_ST_TIMING +: 4] = timing;
    stat_word[`DIL_ST_SEAL +: 4] = seal;
    stat_word[`DIL_ST_BYP +: 4] = byp;
    stat_word[`DIL_ST_INH +: 2] = inh_s;
    stat_word[`DIL_ST_AUTO] = auto_open;
    stat_word[`DIL_ST_TALM] = timing_alarm_r;
    stat_word[`DIL_ST_IALM] = inhibit_alarm_r;
    valve_word = 32'h0;
    valve_word[`DIL_VS_SOL +: NV] = valve_sol_r;
    valve_word[`DIL_VS_BUSB +: NV] = valve_bus_b_r;
    valve_word[`DIL_VS_TRB] = train_b_bus_b_r;
  end

  // Read data are captured when the address is taken and held until rready.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DIL_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DIL_RESP_OKAY;
      case (rofs)
        `DIL_CTRL_OFS: begin
          s_axi_rdata <= 32'h0;
        end
        `DIL_STAT_OFS: begin
          s_axi_rdata <= stat_word;
        end
        `DIL_VALVE_OFS: begin
          s_axi_rdata <= valve_word;
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `DIL_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### sim/dil_top_properties.sv
// Port-level assertions for the depressurization initiation logic top.
`timescale 1ns/100ps
module dil_top_checker #(
  parameter NV = 7
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] level_low_low_in,
  input wire [3:0] level_low_in,
  input wire [1:0] inhibit_key_in,
  input wire act_reset_pb_in,
  input wire logic_reset_pb_in,
  input wire [NV-1:0] manual_open_in,
  input wire [NV-1:0] backup_ovp_in,
  input wire bus_a_ok_in,
  input wire [NV-1:0] valve_bus_a_ok_in,
  input wire [NV-1:0] valve_sol_r,
  input wire [NV-1:0] sol_lamp_r,
  input wire timing_alarm_r,
  input wire inhibit_alarm_r,
  input wire [1:0] inhibit_lamp_r,
  input wire train_b_bus_b_r,
  input wire [NV-1:0] valve_bus_b_r
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Five steady samples cover both synchronizer stages and the output register.
  sequence keys_steady;
    $stable(inhibit_key_in) [*5];
  endsequence
  sequence logic_reset_held;
    (logic_reset_pb_in && level_low_in == 4'h0 && (manual_open_in | backup_ovp_in) == '0) [*6];
  endsequence
  sequence act_reset_held;
    (act_reset_pb_in && (manual_open_in | backup_ovp_in) == '0) [*6];
  endsequence
  sequence both_keys_held;
    (inhibit_key_in == 2'h3 && (manual_open_in | backup_ovp_in) == '0) [*6];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_inhibit_alarm_any: assert property (keys_steady |-> inhibit_alarm_r == (inhibit_key_in != 2'h0))
    else $error("inhibit alarm does not follow the keys");
  a_inhibit_lamp_each: assert property (keys_steady |-> inhibit_lamp_r == inhibit_key_in)
    else $error("inhibit lamps do not follow the keys");
  a_both_keys_block: assert property (both_keys_held |-> !$rose(|valve_sol_r))
    else $error("valve opened with both keys in inhibit");
  a_demand_opens_valve: assert property (($stable(manual_open_in) && $stable(backup_ovp_in)) [*5] |->
    (valve_sol_r & (manual_open_in | backup_ovp_in)) == (manual_open_in | backup_ovp_in))
    else $error("manual or backup demand did not open its valve");
  a_lamp_follows_sol: assert property (sol_lamp_r == valve_sol_r || sol_lamp_r == $past(valve_sol_r))
    else $error("solenoid lamp differs from solenoid");
  a_timing_needs_level: assert property ($rose(timing_alarm_r) |-> $past(level_low_low_in, 3) != 4'h0 ||
    $past(level_low_low_in, 4) != 4'h0 || $past(level_low_low_in, 5) != 4'h0)
    else $error("timing alarm rose without low-low level");
  // Healthy-bus synchronisers restart low, so the first clocks after reset are skipped.
  a_train_b_bus: assert property ($stable(bus_a_ok_in) [*5] ##0 $past(aresetn, 3) |->
    train_b_bus_b_r == !bus_a_ok_in)
    else $error("train B supply selection wrong");
  a_valve_bus_sel: assert property ($stable(valve_bus_a_ok_in) [*5] ##0 $past(aresetn, 3) |->
    valve_bus_b_r == ~valve_bus_a_ok_in)
    else $error("valve supply selection wrong");
  a_logic_reset_close: assert property (logic_reset_held |-> valve_sol_r == '0)
    else $error("logic reset did not close all valves");
  a_act_reset_close: assert property (act_reset_held |-> valve_sol_r == '0)
    else $error("actuation timer reset did not stop blowdown");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not returned one cycle after the address");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped before rready");
endmodule

bind dil_top dil_top_checker #(.NV(NV)) dil_top_checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .level_low_low_in(level_low_low_in), .level_low_in(level_low_in), .inhibit_key_in(inhibit_key_in),
  .act_reset_pb_in(act_reset_pb_in), .logic_reset_pb_in(logic_reset_pb_in), .manual_open_in(manual_open_in),
  .backup_ovp_in(backup_ovp_in), .bus_a_ok_in(bus_a_ok_in), .valve_bus_a_ok_in(valve_bus_a_ok_in),
  .valve_sol_r(valve_sol_r), .sol_lamp_r(sol_lamp_r), .timing_alarm_r(timing_alarm_r),
  .inhibit_alarm_r(inhibit_alarm_r), .inhibit_lamp_r(inhibit_lamp_r), .train_b_bus_b_r(train_b_bus_b_r),
  .valve_bus_b_r(valve_bus_b_r));

// ### sim/dil_plant_model.sv
// Trip units and pump pressure switches feeding the initiation logic.
`timescale 1ns/100ps
module dil_plant_model (
  input wire aclk,
  input wire [3:0] ll_cmd,
  input wire [3:0] lo_cmd,
  input wire [3:0] hp_cmd,
  input wire [5:0] pump_cmd,
  output reg [3:0] ll_out,
  output reg [3:0] lo_out,
  output reg [3:0] hp_out,
  output reg [3:0] lpi_out,
  output reg [1:0] spray_out
);
  initial {ll_out, lo_out, hp_out, lpi_out, spray_out} = 18'h0;
  // Trip units settle one cycle after the process variable crosses its setting.
  always @(posedge aclk) begin
    ll_out <= ll_cmd;
    lo_out <= lo_cmd;
    hp_out <= hp_cmd;
    lpi_out <= pump_cmd[3:0];
    spray_out <= pump_cmd[5:4];
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the depressurization initiation logic.
`timescale 1ns/100ps
`include "dil_defines.vh"
module tb_top;
  localparam NV = 7;
  localparam TC = 4;
  localparam BT = 20;
  localparam AT = 10;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, slow = 1'h0, bus_ok = 1'h1;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, rnd = 32'hDD781BE7, rd;
  reg [3:0] ll_cmd = 4'h0, lo_cmd = 4'h0, hp_cmd = 4'h0, pb = 4'h0;
  reg [5:0] pump_cmd = 6'h00;
  reg [1:0] keys = 2'h0, rsp;
  reg [NV-1:0] man = 7'h00, bak = 7'h00, vok = 7'h7F;
  reg [11:0] v;
  reg [11:0] vq[$] = '{12'hF04, 12'hF0B, 12'hF08, 12'hF11, 12'hF22, 12'hF40, 12'hF80, 12'hF00, 12'h304, 12'hC04,
    12'h504};
  wire awready, wready, bvalid, arready, rvalid, talm, ialm, trbb;
  wire [1:0] bresp, rresp, ilamp, spray;
  wire [31:0] rdata;
  wire [3:0] ll, lo, hp, lpi;
  wire [NV-1:0] sol, lamp, vbb;
  integer bad_count = 0, checks_done = 0, n = 0, k;

  always #25 aclk = ~aclk;

  dil_top #(.NV(NV), .TICK_CYC(TC), .BYP_TICKS(BT), .ACT_TICKS(AT)) dil_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .level_low_low_in(ll), .level_low_in(lo), .cont_press_high_in(hp),
    .low_pressure_injection_press_in(lpi), .spray_pump_press_in(spray), .inhibit_key_in(keys),
    .seal_reset_pb_in(pb[0]), .bypass_reset_pb_in(pb[1]), .act_reset_pb_in(pb[2]), .logic_reset_pb_in(pb[3]),
    .manual_open_in(man), .backup_ovp_in(bak), .bus_a_ok_in(bus_ok), .valve_bus_a_ok_in(vok),
    .valve_sol_r(sol), .sol_lamp_r(lamp), .timing_alarm_r(talm), .inhibit_alarm_r(ialm),
    .inhibit_lamp_r(ilamp), .train_b_bus_b_r(trbb), .valve_bus_b_r(vbb));
  dil_plant_model dil_plant_model_i (.aclk(aclk), .ll_cmd(ll_cmd), .lo_cmd(lo_cmd), .hp_cmd(hp_cmd),
    .pump_cmd(pump_cmd), .ll_out(ll), .lo_out(lo), .hp_out(hp), .lpi_out(lpi), .spray_out(spray));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference model: any permissive, not both keys, and one whole train.
  function automatic bit exp_open(input [11:0] e);
    exp_open = (e[7:2] != 6'h00) && (e[1:0] != 2'h3) && (e[9:8] == 2'h3 || e[11:10] == 2'h3);
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input string what, input [31:0] seen, input [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge aclk);
  endtask
  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= !slow;
    for (t = 0; t < 50; t = t + 1) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'h1;
    end
    check("bresp", bresp, er);
    bready <= 1'h0;
    if (t == 50) check("write_timeout", 1'h1, 1'h0);
    if (t == 50) end_of_test;
  endtask
  task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    integer t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= !slow;
    for (t = 0; t < 50; t = t + 1) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'h1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (t == 50) check("read_timeout", 1'h1, 1'h0);
    if (t == 50) end_of_test;
  endtask
  task wait_sol(input [NV-1:0] e, input integer lim);
    integer t;
    for (t = 0; t < lim && sol !== e; t = t + 1) @(posedge aclk);
    check("valve_sol", sol, e);
    if (sol !== e) end_of_test;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    aresetn <= 1'h1;
    cyc(1);
    check("reset_outputs", {sol, talm, ialm, ilamp, awready, wready, arready, bvalid, rvalid}, 16'h001C);
    cyc(6);
    axi_rd(8'h0C, rd, rsp);
    check("unmapped_rdata", rd, 32'h0);
    check("unmapped_rresp", rsp, 2'h2);
    axi_wr(8'h0C, rnd, 2'h2);
    axi_rd(`DIL_CTRL_OFS, rd, rsp);
    check("ctrl_read", rd, 32'h0);
    while (vq.size() > 0) begin
      v = vq.pop_front();
      @(posedge aclk);
      {ll_cmd, lo_cmd, hp_cmd, pump_cmd, keys} <= {v[11:8], v[11:8], v[11:8], v[7:0]};
      cyc(7);
      hp_cmd <= 4'h0;
      check("timing_alarm", talm, 1'h1);
      check("inhibit_ind", {ialm, ilamp}, {v[1:0] != 2'h0, v[1:0]});
      axi_rd(`DIL_STAT_OFS, rd, rsp);
      check("seal", rd[11:8], v[11:8]);
      cyc((AT - 4) * TC);
      check("early_sol", sol, 7'h00);
      if (exp_open(v)) begin
        wait_sol(7'h7F, 100);
        check("sol_lamp", lamp, 7'h7F);
      end else begin
        cyc(60);
        check("blocked_sol", sol, 7'h00);
      end
      lo_cmd <= n[0] ? 4'h0 : lo_cmd;
      pb <= n[0] ? 4'h8 : 4'h4;
      cyc(8);
      check("closed_sol", sol, 7'h00);
      {ll_cmd, lo_cmd, pump_cmd, keys} <= 16'h0;
      cyc(4);
      pb <= 4'h0;
      n = n + 1;
      axi_wr(`DIL_CTRL_OFS, 32'hF, 2'h0);
    end
    @(posedge aclk);
    {ll_cmd, lo_cmd, pump_cmd} <= 14'h3F01;
    cyc((BT - 3) * TC);
    check("pre_bypass_sol", sol, 7'h00);
    wait_sol(7'h7F, 200);
    axi_rd(`DIL_STAT_OFS, rd, rsp);
    check("bypass_set", rd[15:12], 4'hF);
    {ll_cmd, lo_cmd, pump_cmd} <= 14'h0;
    pb <= 4'hF;
    cyc(8);
    pb <= 4'h0;
    ll_cmd <= 4'hF;
    cyc(6);
    ll_cmd <= 4'h0;
    cyc(30);
    check("held_bypass_timer", talm, 1'h1);
    axi_wr(`DIL_CTRL_OFS, 32'h2, 2'h0);
    cyc(4);
    check("bypass_cleared", talm, 1'h0);
    ll_cmd <= 4'hF;
    cyc(6);
    ll_cmd <= 4'h0;
    cyc(BT * TC + 20);
    axi_rd(`DIL_STAT_OFS, rd, rsp);
    check("no_bypass", rd[15:12], 4'h0);
    check("expired_alarm", talm, 1'h0);
    for (k = 0; k < 4; k = k + 1) begin
      rnd = lfsr(rnd);
      slow <= k[0];
      {bus_ok, vok, bak, man} <= {rnd[24], rnd[22:16], rnd[14:8], rnd[6:0]};
      cyc(6);
      check("sol", sol, man | bak);
      check("lamp", lamp, man | bak);
      check("valve_bus", vbb, vok ^ 7'h7F);
      check("train_bus", trbb, !bus_ok);
      axi_wr(`DIL_STAT_OFS, rnd, 2'h0);
      axi_rd(`DIL_VALVE_OFS, rd, rsp);
      check("valve_reg", rd, {15'h0, !bus_ok, 1'h0, ~vok, 1'h0, man | bak});
    end
    end_of_test;
  end
endmodule
